// >>> inc/cfg_space_cfg.svh
// Purpose: constants for the port configuration space decoder
// Assumes: 16-bit flat system address, 12-bit port-relative offset
// Notes: offsets here are dword aligned region bounds inside one port space
`ifndef CFG_SPACE_CFG_SVH
`define CFG_SPACE_CFG_SVH

`define SYS_ADDR_W 16
`define PORT_NUM_W 4
`define OFFSET_W 12
`define PORT_STRIDE 16'h1000
`define UPSTREAM_PORT 4'h0
`define NUM_PORTS 16
// common header and pcie, pm, ssid and aer capabilities, both layouts
`define OFF_HDR_LO 12'h000
`define OFF_HDR_HI 12'h053
`define OFF_PCIE2_LO 12'h064
`define OFF_PCIE2_HI 12'h073
`define OFF_PM_LO 12'h0C0
`define OFF_PM_HI 12'h0C7
`define OFF_SSID_LO 12'h0F0
`define OFF_SSID_HI 12'h0FF
`define OFF_AER_LO 12'h100
`define OFF_AER_HI 12'h147
// downstream only: message interrupt capability
`define OFF_MSI_LO 12'h0D0
`define OFF_MSI_HI 12'h0DF
// upstream only: global control, global status, test mode
`define OFF_GCTL_LO 12'h400
`define OFF_GCTL_HI 12'h4FF
`define OFF_GSTS_LO 12'h500
`define OFF_GSTS_HI 12'h5FF
`define OFF_TEST_LO 12'h600
`define OFF_TEST_HI 12'h6FF
`define SMBUS_UNDEF_DATA 32'hFFFFFFFF

`endif

// >>> inc/cfg_space_pkg.sv
// Purpose: types shared by the configuration space decoder
// Assumes: constants come from cfg_space_cfg.svh
// Notes: none
`include "cfg_space_cfg.svh"
package cfg_space_pkg;
  typedef enum logic [1:0] {SRC_PCIE, SRC_SMBUS, SRC_EEPROM} src_t;
  typedef enum logic [2:0] {
    RGN_NONE, RGN_COMMON, RGN_MSI, RGN_GCTL, RGN_GSTS, RGN_TEST
  } region_t;
  typedef struct packed {
    logic valid;
    logic write;
    src_t src;
    logic [`SYS_ADDR_W-1:0] sys_addr;
    logic [31:0] wdata;
  } acc_req_t;
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } acc_rsp_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [`PORT_NUM_W-1:0] port;
    logic [`OFFSET_W-1:0] offset;
    region_t region;
    logic [31:0] wdata;
  } reg_req_t;
endpackage

// >>> hw/region_decode.sv
// Purpose: classify one port-relative offset into a register region
// Assumes: upstream layout differs from downstream only in listed regions
// Notes: purely combinational
`timescale 1ns/1ps
`include "cfg_space_cfg.svh"
module region_decode
  import cfg_space_pkg::*;
(
  // address in
  input wire logic upstream,
  input wire logic [`OFFSET_W-1:0] offset,
  // result
  output region_t region
);
  function automatic logic in_rng(input logic [`OFFSET_W-1:0] a,
                                  input logic [`OFFSET_W-1:0] lo,
                                  input logic [`OFFSET_W-1:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    region = RGN_NONE;
    if (in_rng(offset, `OFF_HDR_LO, `OFF_HDR_HI) ||
        in_rng(offset, `OFF_PCIE2_LO, `OFF_PCIE2_HI) ||
        in_rng(offset, `OFF_PM_LO, `OFF_PM_HI) ||
        in_rng(offset, `OFF_SSID_LO, `OFF_SSID_HI) ||
        in_rng(offset, `OFF_AER_LO, `OFF_AER_HI)) begin
      region = RGN_COMMON;
    end else if (!upstream && in_rng(offset, `OFF_MSI_LO, `OFF_MSI_HI)) begin
      region = RGN_MSI;
    end else if (upstream && in_rng(offset, `OFF_GCTL_LO, `OFF_GCTL_HI)) begin
      region = RGN_GCTL;
    end else if (upstream && in_rng(offset, `OFF_GSTS_LO, `OFF_GSTS_HI)) begin
      region = RGN_GSTS;
    end else if (upstream && in_rng(offset, `OFF_TEST_LO, `OFF_TEST_HI)) begin
      region = RGN_TEST;
    end
  end
endmodule

// >>> hw/cfg_space_decoder.sv
// Purpose: decode flat system addresses into port spaces and filter accesses
// Assumes: one access at a time; register storage answers in the same cycle
// Notes: undefined offsets never reach storage
//
// Behaviour
// - every register lives in exactly one port space, so the root reaches all of them.
// - a register's system address is its port base plus its offset in that port.
// - eeprom and smbus accesses name the register by its flat system address.
// - port spaces are 0x1000 apart, port 0 upstream at 0x0000 up to port 15 at 0xF000.
// - global control, global status and test registers exist only in the upstream space.
// - each downstream port has a message interrupt capability, the upstream none.
// - a pcie configuration read of an undefined offset returns zero.
// - an smbus read of an undefined offset returns data nobody may rely on.
// - writes to undefined offsets complete but store nothing and have no effect.
`timescale 1ns/1ps
`include "cfg_space_cfg.svh"
module cfg_space_decoder
  import cfg_space_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // access from pcie, smbus or eeprom loader
  input acc_req_t req,
  output acc_rsp_t rsp,
  // pcie config access by port and offset
  input wire logic pcie_valid,
  input wire logic pcie_write,
  input wire logic [`PORT_NUM_W-1:0] pcie_port,
  input wire logic [`OFFSET_W-1:0] pcie_offset,
  input wire logic [31:0] pcie_wdata,
  output acc_rsp_t pcie_rsp,
  // register storage side
  output reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  // per-port hit, for observation
  output logic [`NUM_PORTS-1:0] port_hit
);
  logic [`PORT_NUM_W-1:0] port_sel;
  logic [`OFFSET_W-1:0] off_sel;
  logic acc_valid, acc_write, acc_pcie;
  logic [31:0] acc_wdata;
  region_t region;
  logic [`NUM_PORTS-1:0] hit_nxt;
  logic pend_r, pend_pcie_r, pend_write_r, pend_defined_r;
  logic pcie_valid_q;

  function automatic logic [`SYS_ADDR_W-1:0] port_base(
      input logic [`PORT_NUM_W-1:0] p);
    port_base = `SYS_ADDR_W'(p) * `PORT_STRIDE;
  endfunction

  // pcie has priority: host config traffic must not be starved
  always_comb begin
    acc_pcie = pcie_valid;
    if (pcie_valid) begin
      acc_valid = 1'b1;
      acc_write = pcie_write;
      port_sel = pcie_port;
      off_sel = pcie_offset;
      acc_wdata = pcie_wdata;
    end else begin
      acc_valid = req.valid;
      acc_write = req.write;
      // flat address split: port by field cut, port base subtracted for the offset
      port_sel = req.sys_addr[`SYS_ADDR_W-1 -: `PORT_NUM_W];
      off_sel = `OFFSET_W'(req.sys_addr - port_base(port_sel));
      acc_wdata = req.wdata;
      acc_pcie = (req.src == SRC_PCIE);
    end
  end

  region_decode u_region (
    .upstream(port_sel == `UPSTREAM_PORT),
    .offset(off_sel),
    .region(region)
  );

  // one-hot port select so each register has one owner
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PORTS; gi++) begin : g_hit
      assign hit_nxt[gi] = acc_valid && (port_sel == `PORT_NUM_W'(gi));
    end
  endgenerate

  // storage strobe only for defined offsets
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_req <= '0;
    end else begin
      reg_req.valid <= acc_valid && (region != RGN_NONE);
      reg_req.write <= acc_write;
      reg_req.port <= port_sel;
      reg_req.offset <= off_sel;
      reg_req.region <= region;
      reg_req.wdata <= acc_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
      pend_pcie_r <= 1'b0;
      pend_write_r <= 1'b0;
      pend_defined_r <= 1'b0;
    end else begin
      pend_r <= acc_valid;
      pend_pcie_r <= acc_pcie;
      pend_write_r <= acc_write;
      pend_defined_r <= (region != RGN_NONE);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_hit <= '0;
    end else begin
      port_hit <= hit_nxt;
    end
  end

  // answer one cycle after the storage strobe; writes always complete
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp <= '0;
      pcie_rsp <= '0;
    end else begin
      rsp.valid <= pend_r && !(pend_pcie_r && pcie_valid_q);
      pcie_rsp.valid <= pend_r && pcie_valid_q;
      // both rdata outputs move with every answer on either port, so each holds until the next answer on either port
      if (pend_r && pend_write_r) begin
        rsp.rdata <= '0;
        pcie_rsp.rdata <= '0;
      end else if (pend_r && pend_defined_r) begin
        rsp.rdata <= reg_rdata;
        pcie_rsp.rdata <= reg_rdata;
      end else if (pend_r) begin
        rsp.rdata <= pend_pcie_r ? 32'h0 : `SMBUS_UNDEF_DATA;
        pcie_rsp.rdata <= 32'h0;
      end
    end
  end

  // remembers whether the pending access came over the pcie port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pcie_valid_q <= 1'b0;
    end else begin
      pcie_valid_q <= pcie_valid;
    end
  end
endmodule

// >>> dv/reg_store_model.sv
// Purpose: register storage behind the decoder
// Assumes: rdata sampled in the strobe cycle or the one after
// Notes: data encodes port and offset so misrouting shows
`timescale 1ns/1ps
module reg_store_model
  import cfg_space_pkg::*;
(
  // clock
  input wire logic clk,
  // strobe in, data out
  input reg_req_t reg_req,
  output logic [31:0] reg_rdata
);
  logic [31:0] last_r;
  logic hold_r;
  always_ff @(posedge clk) begin
    hold_r <= reg_req.valid;
    if (reg_req.valid) last_r <= {16'hA5C3, reg_req.port, reg_req.offset};
  end
  // stale data inverted after its hold, so late sampling shows
  assign reg_rdata = reg_req.valid ? {16'hA5C3, reg_req.port, reg_req.offset} :
                     hold_r ? last_r : ~last_r;
endmodule

// >>> dv/cfg_space_decoder_asserts.sv
// Purpose: decode and timing checks on the decoder ports
// Assumes: one clock, async active low reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`include "cfg_space_cfg.svh"
module cfg_space_decoder_chk
  import cfg_space_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // observed ports
  input acc_req_t req,
  input acc_rsp_t rsp,
  input wire logic pcie_valid,
  input wire logic pcie_write,
  input acc_rsp_t pcie_rsp,
  input reg_req_t reg_req,
  input logic [`NUM_PORTS-1:0] port_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence flat_take;
    req.valid && !pcie_valid;
  endsequence
  sequence pcie_undef_rd;
    pcie_valid && !pcie_write ##1 !reg_req.valid;
  endsequence
  a_addr_split: assert property (
    flat_take ##1 reg_req.valid |-> reg_req.port == $past(req.sys_addr[15:12])
      && reg_req.offset == $past(req.sys_addr[11:0])) else $error("bad port split");
  a_port_hit: assert property (
    flat_take |=> port_hit == 16'h0001 << $past(req.sys_addr[15:12])) else $error("bad hit");
  a_rsp_lat: assert property (
    flat_take |-> ##2 rsp.valid) else $error("no flat answer");
  a_pcie_lat: assert property (
    pcie_valid |-> ##2 pcie_rsp.valid) else $error("no pcie answer");
  a_up_nomsi: assert property (
    reg_req.valid && reg_req.port == 4'h0 |-> reg_req.region != RGN_MSI) else $error("msi up");
  a_dn_noglobal: assert property (
    reg_req.valid && reg_req.port != 4'h0 |-> reg_req.region inside {RGN_COMMON, RGN_MSI})
    else $error("global reg downstream");
  a_undef_zero: assert property (
    pcie_undef_rd |=> pcie_rsp.rdata == 32'h0) else $error("undefined read not zero");
  a_undef_nostore: assert property (
    reg_req.valid |-> reg_req.region != RGN_NONE) else $error("undefined reached storage");
endmodule
bind cfg_space_decoder cfg_space_decoder_chk u_chk (.clk(clk), .reset_n(reset_n), .req(req),
  .rsp(rsp), .pcie_valid(pcie_valid), .pcie_write(pcie_write), .pcie_rsp(pcie_rsp),
  .reg_req(reg_req), .port_hit(port_hit));

// >>> dv/switch_config_space_decoder_tb.sv
// Purpose: directed bench for the config space decoder
// Assumes: storage model answers in the strobe cycle
// Notes: expected read data mirrors the model's port and offset pattern
`timescale 1ns/1ps
`include "cfg_space_cfg.svh"
module switch_config_space_decoder_tb;
  import cfg_space_pkg::*;
  logic clk = 0, reset_n = 0, pcie_valid = 0, pcie_write = 0;
  logic [3:0] pcie_port = '0;
  logic [11:0] pcie_offset = '0;
  logic [31:0] pcie_wdata = '0, reg_rdata, rd;
  logic [15:0] port_hit, hit;
  acc_req_t req = '0;
  acc_rsp_t rsp, pcie_rsp;
  reg_req_t reg_req, seen;
  int err_total = 0, samples_checked = 0, cycles = 0;
  always #20 clk = ~clk;
  cfg_space_decoder dut (.clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp),
    .pcie_valid(pcie_valid), .pcie_write(pcie_write), .pcie_port(pcie_port),
    .pcie_offset(pcie_offset), .pcie_wdata(pcie_wdata), .pcie_rsp(pcie_rsp),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .port_hit(port_hit));
  reg_store_model store (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pc picks the port-relative path, where a is {port, offset}
  task acc(input logic pc, input logic wr, input logic [15:0] a, input src_t s);
    @(posedge clk);
    #1;
    if (pc) {pcie_valid, pcie_write, pcie_port, pcie_offset} = {1'b1, wr, a};
    else req = '{1'b1, wr, s, a, 32'h1234ABCD};
    pcie_wdata = 32'h1234ABCD;
    @(posedge clk);
    #1;
    pcie_valid = 0;
    req.valid = 0;
    seen = reg_req;
    hit = port_hit;
    @(posedge clk);
    #1;
    rd = pc ? pcie_rsp.rdata : rsp.rdata;
    chk(pc ? pcie_rsp.valid : rsp.valid, 1);
    chk(pc ? rsp.valid : pcie_rsp.valid, 0);
  endtask
  task t_ports;
    for (int p = 0; p < 16; p++) begin
      acc(0, 0, 16'(p * 16'h1000 + 16'h044), SRC_SMBUS);
      chk(seen.port, p[3:0]);
      chk(hit, 32'h1 << p);
      chk(rd, {16'hA5C3, p[3:0], 12'h044});
    end
  endtask
  task t_regions;
    acc(0, 0, 16'h0400, SRC_EEPROM);
    chk(seen.region, RGN_GCTL);
    acc(0, 0, 16'h1500, SRC_EEPROM);
    chk(seen.valid, 0);
    acc(1, 0, 16'h60D0, SRC_PCIE);
    chk(seen.region, RGN_MSI);
    acc(1, 0, 16'h00D4, SRC_PCIE);
    chk(seen.valid, 0);
    chk(rd, 0);
  endtask
  task t_undef;
    acc(1, 0, 16'h2800, SRC_PCIE);
    chk(rd, 0);
    acc(0, 1, 16'h2800, SRC_SMBUS);
    chk(seen.valid, 0);
    acc(0, 1, 16'h2044, SRC_SMBUS);
    chk(seen.wdata, 32'h1234ABCD);
    chk(seen.write, 1);
    acc(0, 0, 16'h3800, SRC_SMBUS);
    chk(seen.valid, 0);
    chk(rd, `SMBUS_UNDEF_DATA);
    acc(0, 0, 16'h3800, SRC_PCIE);
    chk(rd, 0);
    acc(1, 0, 16'h50F0, SRC_PCIE);
    chk(rd, 32'hA5C350F0);
  endtask
  // both sources in one cycle: pcie is served, the flat request is dropped
  task t_clash;
    @(posedge clk);
    #1;
    {pcie_valid, pcie_write, pcie_port, pcie_offset} = {2'b10, 16'h4044};
    req = '{1'b1, 1'b0, SRC_SMBUS, 16'h7044, 32'h1234ABCD};
    @(posedge clk);
    #1;
    pcie_valid = 0;
    req.valid = 0;
    chk(reg_req.port, 4'h4);
    @(posedge clk);
    #1;
    chk(pcie_rsp.valid, 1);
    chk(rsp.valid, 0);
    chk(pcie_rsp.rdata, 32'hA5C34044);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 reset_n = 1;
    t_ports;
    t_regions;
    t_undef;
    t_clash;
    end_of_test;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      end_of_test;
    end
  end
endmodule
